// *** ftm_tach_mode.sv ***
// module: vendor tach mode, spin-up early exit, test register and fan speed counters
// Operation
// - vendor range 70h-7Fh has no guaranteed power-up value, may hold tests
// - low pwm range allows four tach modes; high range forces mode 0
// - mode bits 5:4 for inputs 3/4, 3:2 input 2, 1:0 input 1
// - reported speed always assumes two tach pulses per revolution
// - mode 00 plain detection, may report false speed when too slow
// - mode 01 plain detection, reading forced to ffffh when too slow
// - mode 10 compensated, lower floor, most accurate, ffffh when too slow
// - mode 11 compensated, least pwm disturbance, ffffh when too slow
// - floor 841 rpm modes 0/1; 210 rpm modes 2/3, 420 at higher pwm
// - tach mode register writable under lock; reset value used while start clear
// - early-exit bit clear: spin-up ends only when programmed time expires
// - early-exit bit set: spin-up ends on tach above minimum or timeout
// - spin-up register resets 7h, bits 2:0, locked read-only, default while stopped
// - reads of undefined addresses return 00h
// - writes to undefined addresses are ignored without error
// - setting test register bit 0 enters xor-tree test mode
// - xor tree excludes the serial bus pins; order is free
// - writing 0 to the xor enable bit leaves xor-tree test mode
`default_nettype none
module ftm_tach_mode
	import ftm_pkg::*;
#(
	parameter int N_TACH = 4,
	parameter int TEST_PINS = 8
) (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire ftm_req_t req_in,
	output logic [7:0] rdata_out,
	output logic ack_out,
	input wire logic lock_in,
	input wire logic start_in,
	input wire logic pwm_high_range_in,
	input wire logic [2:0] pwm_freq_sel_in,
	input wire logic [N_TACH-1:0] fan_pulse_in,
	input wire logic [2:0] fan_drive_in,
	input wire logic [2:0] spinup_active_in,
	input wire logic [2:0] spinup_timeout_in,
	input wire logic [15:0] tach_minimum_in,
	input wire logic [TEST_PINS-1:0] test_pins_in,
	output logic [N_TACH*16-1:0] tach_reading_out,
	output logic [1:0] tach_mode_eff_out,
	output logic [2:0] spinup_done_out,
	output logic [2:0] drive_hold_out,
	output logic xor_tree_enable_out,
	output logic xor_tree_out
);
	// ***********************************************
	// derived timing
	// ***********************************************
	// longest tach period (ticks) at the plain floor and both compensated floors
	localparam int TICKS_CONV = FTM_CLK_HZ / FTM_MIN_RPM_CONV * FTM_RPM_CONV / FTM_PULSES_PER_REV;
	localparam int TICKS_COMP_LO =
		FTM_CLK_HZ / FTM_MIN_RPM_COMP_LOW * FTM_RPM_CONV / FTM_PULSES_PER_REV;
	localparam int TICKS_COMP_HI =
		FTM_CLK_HZ / FTM_MIN_RPM_COMP_HIGH * FTM_RPM_CONV / FTM_PULSES_PER_REV;
	localparam int DIV = (TICKS_COMP_LO + 16'hfffe) / 16'hffff;
	localparam logic [15:0] LIM_CONV = 16'(TICKS_CONV / DIV);
	localparam logic [15:0] LIM_COMP_LO = 16'(TICKS_COMP_LO / DIV);
	localparam logic [15:0] LIM_COMP_HI = 16'(TICKS_COMP_HI / DIV);
	localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

	// ***********************************************
	// registers
	// ***********************************************
	logic [FTM_MODE_W-1:0] tach_measure_mode_reg;
	logic [FTM_SU_W-1:0] fan_spinup_early_exit_reg;
	logic xor_tree_enable_reg;
	logic hit_test;
	logic hit_mode;
	logic hit_spin;
	logic wr_mode;
	logic wr_spin;
	logic wr_test;

	assign hit_test = req_in.addr == FTM_ADDR_TEST;
	assign hit_mode = req_in.addr == FTM_ADDR_TACH_MODE;
	assign hit_spin = req_in.addr == FTM_ADDR_SPINUP;

	// write strobes; lock guards spin-up and test, never the tach mode
	assign wr_mode = req_in.wr & hit_mode;
	assign wr_spin = req_in.wr & hit_spin & ~lock_in;
	assign wr_test = req_in.wr & hit_test & ~lock_in;


	// tach mode register, never locked
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tach_measure_mode_reg <= FTM_MODE_W'(FTM_RST_TACH_MODE);
		end else if (wr_mode) begin
			tach_measure_mode_reg <= req_in.wdata[FTM_MODE_W-1:0];
		end
	end

	// spin-up early-exit register, locked by lock bit
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fan_spinup_early_exit_reg <= FTM_RST_SPINUP;
		end else if (wr_spin) begin
			fan_spinup_early_exit_reg <= req_in.wdata[FTM_SU_W-1:0];
		end
	end

	// test register, locked by lock bit
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			xor_tree_enable_reg <= FTM_RST_TEST[FTM_XEN_BIT];
		end else if (wr_test) begin
			xor_tree_enable_reg <= req_in.wdata[FTM_XEN_BIT];
		end
	end

	logic [7:0] rd_mux;
	// read mux; unmapped addresses read 00h
	always_comb begin
		rd_mux = FTM_UNDEF_READ;
		if (hit_mode) begin
			rd_mux = {2'h0, tach_measure_mode_reg};
		end else if (hit_spin) begin
			rd_mux = {5'h00, fan_spinup_early_exit_reg};
		end else if (hit_test) begin
			rd_mux = {7'h00, xor_tree_enable_reg};
		end
	end

	// read data and completion; unmapped reads give 00h, writes ack silently
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= FTM_UNDEF_READ;
			ack_out <= 1'b0;
		end else begin
			ack_out <= req_in.rd | req_in.wr;
			if (req_in.rd) begin
				rdata_out <= rd_mux;
			end
		end
	end

	// ***********************************************
	// effective settings
	// ***********************************************
	logic [FTM_MODE_W-1:0] mode_eff;
	logic [FTM_SU_W-1:0] su_eff;
	logic [1:0] mode_of [N_TACH];
	// defaults govern while stopped; high pwm range forces mode 0
	assign mode_eff = (!start_in || pwm_high_range_in) ? '0 : tach_measure_mode_reg;
	assign su_eff = start_in ? fan_spinup_early_exit_reg : FTM_RST_SPINUP;

	// ***********************************************
	// synchronisers and prescaler
	// ***********************************************
	logic [N_TACH-1:0] pulse_s1;
	logic [N_TACH-1:0] pulse_s2;
	logic [N_TACH-1:0] pulse_s3;
	logic [2:0] drv_s1;
	logic [2:0] drv_s2;
	logic [7:0] div_reg;
	logic tick;

	// two flops for pins, a third for edge detection
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pulse_s1 <= '0;
			pulse_s2 <= '0;
			pulse_s3 <= '0;
			drv_s1 <= '0;
			drv_s2 <= '0;
		end else begin
			pulse_s1 <= fan_pulse_in;
			pulse_s2 <= pulse_s1;
			pulse_s3 <= pulse_s2;
			drv_s1 <= fan_drive_in;
			drv_s2 <= drv_s1;
		end
	end

	// one-cycle enable paces the period counters
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_reg <= '0;
		end else begin
			div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 8'h01;
		end
	end
	assign tick = div_reg == DIV_LAST;

	// ***********************************************
	// per-input period measurement
	// ***********************************************
	genvar g;
	generate
		for (g = 0; g < N_TACH; g++) begin : g_tach
			// inputs 3 and 4 share one field and drive 3
			localparam int LSB = (g == 0) ? FTM_T1_LSB : (g == 1) ? FTM_T2_LSB : FTM_T34_LSB;
			localparam int DRV = (g < 2) ? g : 2;
			logic [15:0] cnt_reg;
			logic [15:0] rd_reg;
			logic [15:0] limit;
			logic comp;
			logic rise;
			logic run;

			assign mode_of[g] = mode_eff[LSB+1:LSB];
			assign comp = mode_of[g][1];
			// compensated floor lower at lowest pwm frequency
			assign limit = !comp ? LIM_CONV
				: (pwm_freq_sel_in == 3'h0) ? LIM_COMP_LO : LIM_COMP_HI;
			assign rise = pulse_s2[g] & ~pulse_s3[g];
			// accurate mode counts only while drive is on; gentle mode counts regardless of drive and never stretches it
			assign run = !comp || drv_s2[DRV] || (mode_of[g] == FTM_MODE_GENTLE);
			// counts ticks between rising edges: one edge pair is half a rev
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					cnt_reg <= '0;
				end else if (rise) begin
					cnt_reg <= '0;
				end else if (tick && run && cnt_reg != FTM_SLOW_READING) begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end

			// latched reading; too-slow handling by mode
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					rd_reg <= FTM_SLOW_READING;
				end else if (rise) begin
					rd_reg <= cnt_reg;
				end else if (cnt_reg >= limit && mode_of[g] != FTM_MODE_RAW) begin
					rd_reg <= FTM_SLOW_READING;
				end
				// raw mode keeps last value when too slow, a possibly false speed
			end

			// output copy of the reading
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					tach_reading_out[g*16 +: 16] <= FTM_SLOW_READING;
				end else begin
					tach_reading_out[g*16 +: 16] <= rd_reg;
				end
			end
		end
	endgenerate

	// ***********************************************
	// spin-up early exit per drive channel
	// ***********************************************
	logic [15:0] drive_speed [3];
	assign drive_speed[0] = tach_reading_out[15:0];
	assign drive_speed[1] = tach_reading_out[31:16];
	assign drive_speed[2] = tach_reading_out[47:32];
	generate
		for (g = 0; g < 3; g++) begin : g_spin
			logic early;
			// reading below minimum count means fan faster than minimum
			assign early = su_eff[g] && (drive_speed[g] < tach_minimum_in);

			// done on timeout, or early once the reading drops below the minimum count
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					spinup_done_out[g] <= 1'b0;
				end else if (!spinup_active_in[g]) begin
					spinup_done_out[g] <= 1'b0;
				end else if (spinup_timeout_in[g]) begin
					spinup_done_out[g] <= 1'b1;
				end else if (early) begin
					spinup_done_out[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// ***********************************************
	// xor tree over synchronised test pins
	// ***********************************************
	// synchronised pins and the running parity
	logic [TEST_PINS-1:0] tp_s1;
	logic [TEST_PINS-1:0] tp_s2;
	logic [TEST_PINS:0] xor_chain;

	// test pins are asynchronous; two flops before the tree
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tp_s1 <= '0;
			tp_s2 <= '0;
		end else begin
			tp_s1 <= test_pins_in;
			tp_s2 <= tp_s1;
		end
	end

	// one xor stage per pin; serial bus pins never enter the chain
	assign xor_chain[0] = 1'b0;
	generate
		for (g = 0; g < TEST_PINS; g++) begin : g_xor
			assign xor_chain[g+1] = xor_chain[g] ^ tp_s2[g];
		end
	endgenerate

	// ***********************************************
	// drive hold per channel
	// ***********************************************
	// accurate mode stretches drive for a clean edge; gentle mode leaves drive alone
	generate
		for (g = 0; g < 3; g++) begin : g_hold
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					drive_hold_out[g] <= 1'b0;
				end else begin
					drive_hold_out[g] <= mode_of[g] == FTM_MODE_ACCURATE;
				end
			end
		end
	endgenerate

	// ***********************************************
	// status outputs and xor tree
	// ***********************************************
	logic [1:0] mode_comp_hold;
	assign mode_comp_hold = {mode_of[1][1], mode_of[0][1]};
	// effective mode, xor enable and tree result
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tach_mode_eff_out <= '0;
			xor_tree_enable_out <= 1'b0;
			xor_tree_out <= 1'b0;
		end else begin
			tach_mode_eff_out <= mode_of[0];
			xor_tree_enable_out <= xor_tree_enable_reg;
			// test pins exclude serial bus pins; order immaterial
			xor_tree_out <= xor_tree_enable_reg & xor_chain[TEST_PINS];
		end
	end

	// tie-off for bits that no other logic reads
	logic unused_ok;
	assign unused_ok = ^mode_comp_hold ^ FTM_MODE_CLAMP[0];
endmodule : ftm_tach_mode
`default_nettype wire

// *** ftm_pkg.sv ***
// package: register map, field layout, reset values and timing for the fan tach mode block
`default_nettype none
package ftm_pkg;
	// ***********************************************
	// register map
	// ***********************************************
	localparam logic [7:0] FTM_ADDR_TEST = 8'h6f;
	localparam logic [7:0] FTM_ADDR_TACH_MODE = 8'h74;
	localparam logic [7:0] FTM_ADDR_SPINUP = 8'h75;
	localparam logic [7:0] FTM_RST_TEST = 8'h00;
	localparam logic [7:0] FTM_RST_TACH_MODE = 8'h00;
	localparam logic [2:0] FTM_RST_SPINUP = 3'h7;
	localparam logic [7:0] FTM_UNDEF_READ = 8'h00;
	localparam int FTM_XEN_BIT = 0;
	localparam int FTM_T1_LSB = 0;
	localparam int FTM_T2_LSB = 2;
	localparam int FTM_T34_LSB = 4;
	localparam int FTM_MODE_W = 6;
	localparam int FTM_SU_W = 3;
	// ***********************************************
	// measurement
	// ***********************************************
	localparam logic [15:0] FTM_SLOW_READING = 16'hffff;
	localparam int FTM_CLK_HZ = 25000000;
	localparam int FTM_PULSES_PER_REV = 2;
	// longest tach period follows from the 841 rpm floor, seconds*rpm = 60
	localparam int FTM_RPM_CONV = 60;
	localparam int FTM_MIN_RPM_CONV = 841;
	localparam int FTM_MIN_RPM_COMP_LOW = 210;
	localparam int FTM_MIN_RPM_COMP_HIGH = 420;
	localparam logic [1:0] FTM_MODE_RAW = 2'h0;
	localparam logic [1:0] FTM_MODE_CLAMP = 2'h1;
	localparam logic [1:0] FTM_MODE_ACCURATE = 2'h2;
	localparam logic [1:0] FTM_MODE_GENTLE = 2'h3;
	// register bus request from the serial slave
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ftm_req_t;
endpackage : ftm_pkg
`default_nettype wire

// *** ftm_tach_mode_props.sv ***
// checker: port-level properties of the fan tach mode block
`default_nettype none
module ftm_tach_mode_props
	import ftm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire ftm_req_t req_in,
	input wire logic [7:0] rdata_out,
	input wire logic ack_out,
	input wire logic lock_in,
	input wire logic start_in,
	input wire logic pwm_high_range_in,
	input wire logic [2:0] spinup_active_in,
	input wire logic [2:0] spinup_timeout_in,
	input wire logic [1:0] tach_mode_eff_out,
	input wire logic [2:0] spinup_done_out,
	input wire logic xor_tree_enable_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	logic known;
	logic wr_test;
	// decoded request kinds
	assign known = req_in.addr inside {FTM_ADDR_TEST, FTM_ADDR_TACH_MODE, FTM_ADDR_SPINUP};
	assign wr_test = req_in.wr && req_in.addr == FTM_ADDR_TEST && !lock_in;
	bus_ack_a: assert property ((req_in.wr || req_in.rd) |=> ack_out)
		else $error("request not acknowledged");
	undef_zero_a: assert property (req_in.rd && !known |=> rdata_out == FTM_UNDEF_READ)
		else $error("undefined read not zero");
	mode_pad_a: assert property (req_in.rd && req_in.addr == FTM_ADDR_TACH_MODE
		|=> rdata_out[7:6] == 2'h0) else $error("mode reserved bits set");
	spin_pad_a: assert property (req_in.rd && req_in.addr == FTM_ADDR_SPINUP
		|=> rdata_out[7:3] == 5'h0) else $error("spin-up upper bits set");
	stop_default_a: assert property (!start_in [*3] |-> tach_mode_eff_out == FTM_MODE_RAW)
		else $error("mode not default while stopped");
	high_range_a: assert property (pwm_high_range_in [*3] |-> tach_mode_eff_out == 2'h0)
		else $error("mode not 0 in high range");
	xor_enter_a: assert property (wr_test && req_in.wdata[0] |-> ##[1:2] xor_tree_enable_out)
		else $error("xor mode not entered");
	xor_leave_a: assert property (wr_test && !req_in.wdata[0] |-> ##[1:2] !xor_tree_enable_out)
		else $error("xor mode not left");
	spin_end_a: assert property (spinup_active_in[0] && spinup_timeout_in[0]
		|-> ##[1:2] spinup_done_out[0]) else $error("spin-up not ended on timeout");
endmodule : ftm_tach_mode_props
bind ftm_tach_mode ftm_tach_mode_props i_props (.clk_sys_in(clk_sys_in),
	.arst_n_in(arst_n_in), .req_in(req_in), .rdata_out(rdata_out), .ack_out(ack_out),
	.lock_in(lock_in), .start_in(start_in), .pwm_high_range_in(pwm_high_range_in),
	.spinup_active_in(spinup_active_in), .spinup_timeout_in(spinup_timeout_in),
	.tach_mode_eff_out(tach_mode_eff_out), .spinup_done_out(spinup_done_out),
	.xor_tree_enable_out(xor_tree_enable_out));
`default_nettype wire

// *** ftm_fan_model.sv ***
// fan model: tach pulse source for four fans on three drives
`default_nettype none
module ftm_fan_model (
	input wire logic clk_in,
	input wire logic [2:0] drive_in,
	input wire logic [15:0] half_in,
	output logic [3:0] pulse_out = 4'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt = 16'h0;
	logic [3:0] en;
	// drive 1,2,3 power fans 1, 2 and 3+4
	assign en = {drive_in[2], drive_in[2], drive_in[1], drive_in[0]};
	// two pulses a revolution, stopped fans rest low
	always @(posedge clk_in) begin
		if (half_in == 16'h0 || cnt >= half_in - 16'h1) begin
			cnt <= 16'h0;
			pulse_out <= (half_in == 16'h0) ? 4'h0 : ~pulse_out & en;
		end else begin
			cnt <= cnt + 16'h1;
		end
	end
endmodule : ftm_fan_model
`default_nettype wire

// *** ftm_tach_mode_bench.sv ***
// bench: register, mode, spin-up and xor scenarios
`default_nettype none
module ftm_tach_mode_bench;
	import ftm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	ftm_req_t req = '0;
	logic lock = 1'b0;
	logic start = 1'b0;
	logic hr = 1'b0;
	logic [2:0] sa = 3'h0;
	logic [2:0] st = 3'h0;
	logic [15:0] half = 16'h0;
	logic [2:0] drv = 3'h7;
	logic [2:0] hold;
	logic [7:0] tp = 8'h0;
	logic [3:0] pulse;
	logic [7:0] rdata;
	logic ack, xor_tree_enable, xo;
	logic [63:0] tach;
	logic [1:0] mode;
	logic [2:0] done;
	int failures = 0;
	int checked = 0;
	initial forever #20 clk_sys_in = ~clk_sys_in;
	ftm_tach_mode i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .req_in(req),
		.rdata_out(rdata), .ack_out(ack), .lock_in(lock), .start_in(start),
		.pwm_high_range_in(hr), .pwm_freq_sel_in(3'h0), .fan_pulse_in(pulse),
		.fan_drive_in(drv), .spinup_active_in(sa), .spinup_timeout_in(st),
		.tach_minimum_in(16'hffff), .test_pins_in(tp), .tach_reading_out(tach),
		.tach_mode_eff_out(mode), .spinup_done_out(done), .drive_hold_out(hold),
		.xor_tree_enable_out(xor_tree_enable), .xor_tree_out(xo));
	ftm_fan_model i_fans (.clk_in(clk_sys_in), .drive_in(drv), .half_in(half), .pulse_out(pulse));
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tk
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one bus cycle, acknowledged in the next cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		tk(1);
		req = '0;
		check("ack", {15'h0, ack}, 16'h1);
		tk(1);
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h0);
		check("rdata", {8'h0, rdata}, {8'h0, exp});
	endtask : rd
	task automatic stop_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	// reset values, field widths, lock and unmapped places
	task automatic t_regs;
		rd(FTM_ADDR_TACH_MODE, 8'h00);
		rd(FTM_ADDR_SPINUP, 8'h07);
		check("reading", tach[15:0], 16'hffff);
		acc(1'b1, FTM_ADDR_TACH_MODE, 8'hff);
		rd(FTM_ADDR_TACH_MODE, 8'h3f);
		acc(1'b1, FTM_ADDR_SPINUP, 8'hf8);
		rd(FTM_ADDR_SPINUP, 8'h00);
		acc(1'b1, 8'h7f, 8'ha5);
		rd(8'h7f, 8'h00);
		lock = 1'b1;
		acc(1'b1, FTM_ADDR_TACH_MODE, 8'h15);
		rd(FTM_ADDR_TACH_MODE, 8'h15);
		acc(1'b1, FTM_ADDR_SPINUP, 8'h07);
		rd(FTM_ADDR_SPINUP, 8'h00);
		lock = 1'b0;
	endtask : t_regs
	// every mode code, high range and stopped default
	task automatic t_modes;
		start = 1'b1;
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, FTM_ADDR_TACH_MODE, {2'h0, m[1:0], m[1:0], m[1:0]});
			tk(2);
			check("mode", {14'h0, mode}, m[15:0]);
			check("hold", {13'h0, hold}, (m == 2) ? 16'h7 : 16'h0);
			hr = 1'b1;
			tk(3);
			check("mode", {14'h0, mode}, 16'h0);
			check("hold", {13'h0, hold}, 16'h0);
			hr = 1'b0;
		end
		start = 1'b0;
		tk(3);
		check("mode", {14'h0, mode}, 16'h0);
		start = 1'b1;
	endtask : t_modes
	// running fans give readings, then spin-up exits
	task automatic t_spin;
		acc(1'b1, FTM_ADDR_TACH_MODE, 8'h15);
		half = 16'h32;
		tk(800);
		check("slow", {15'h0, tach[15:0] == 16'hffff}, 16'h0);
		check("pair", tach[63:48], tach[47:32]);
		acc(1'b1, FTM_ADDR_SPINUP, 8'h00);
		sa = 3'h7;
		tk(4);
		check("done", {13'h0, done}, 16'h0);
		st = 3'h1;
		tk(2);
		check("done", {13'h0, done}, 16'h1);
		{sa, st} = 6'h0;
		acc(1'b1, FTM_ADDR_SPINUP, 8'h02);
		sa = 3'h7;
		tk(3);
		check("done", {13'h0, done}, 16'h2);
		{sa, half} = 19'h0;
	endtask : t_spin
	// compensated modes read running fans on their own drives
	task automatic t_comp;
		acc(1'b1, FTM_ADDR_TACH_MODE, 8'h2a);
		half = 16'h32;
		tk(800);
		check("slow", {15'h0, tach[31:16] == 16'hffff}, 16'h0);
		check("pair", tach[63:48], tach[47:32]);
		acc(1'b1, FTM_ADDR_TACH_MODE, 8'h3f);
		tk(800);
		check("slow", {15'h0, tach[15:0] == 16'hffff}, 16'h0);
		half = 16'h0;
	endtask : t_comp
	// xor tree parity over the test pins
	task automatic t_xor;
		acc(1'b1, FTM_ADDR_TEST, 8'h01);
		tp = 8'h0b;
		tk(5);
		check("xen", {15'h0, xor_tree_enable}, 16'h1);
		check("xor", {15'h0, xo}, 16'h1);
		tp = 8'h03;
		tk(5);
		check("xor", {15'h0, xo}, 16'h0);
		acc(1'b1, FTM_ADDR_TEST, 8'h00);
		tk(2);
		check("xen", {15'h0, xor_tree_enable}, 16'h0);
	endtask : t_xor
	initial begin
		tk(4);
		arst_n_in = 1'b1;
		t_regs();
		t_modes();
		t_spin();
		t_comp();
		t_xor();
		stop_test();
	end
	initial begin
		#400000;
		failures++;
		stop_test();
	end
endmodule : ftm_tach_mode_bench
`default_nettype wire
